// *** hdl/pbl_defs.svh ***
`ifndef PBL_DEFS_SVH
`define PBL_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PBL_OFF_DIR      4'h0
`define PBL_OFF_DATA     4'h1
`define PBL_OFF_PAT_EN   4'h2
`define PBL_OFF_PAT_NXT  4'h3
`define PBL_OFF_TMODE    4'h4
`define PBL_OFF_TFUNC    4'h5
`define PBL_OFF_TOE      4'h6
`define PBL_OFF_TIO      4'h7
`define PBL_OFF_XFER     4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PBL_BIT_PIN0     0
`define PBL_BIT_PIN1     1
`define PBL_BIT_CHAN3_PWM_SELECT     3
`define PBL_BIT_CMD      5
`define PBL_BIT_EA3      3
`define PBL_BIT_EB3      4
`define PBL_PAT_BIT8     0
`define PBL_PAT_BIT9     1

// ----------------------------------------
// Reset value and unmapped-offset read value
// ----------------------------------------
`define PBL_RST_REG      8'h00
`define PBL_RD_UNMAPPED  8'h00

`endif

// *** hdl/pbl_pkg.sv ***
package pbl_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pbl_bus_t;

	typedef enum logic [1:0] {
		PBL_FN_GP_IN,
		PBL_FN_GP_OUT,
		PBL_FN_PATTERN,
		PBL_FN_TIMER
	} pbl_fn_t;

	typedef struct packed {
		logic       dir;
		logic       pat_en;
		logic       tmr_oe;
		logic       cmd;
		logic       pwm;
		logic [2:0] io;
	} pbl_sel_in_t;
endpackage

// *** hdl/pbl_pin_sel.sv ***
`include "pbl_defs.svh"

module pbl_pin_sel #(
	parameter bit IS_A = 1'b0
) (
	// Selection controls
	input  pbl_pkg::pbl_sel_in_t sel,
	// Result
	output pbl_pkg::pbl_fn_t     fn,
	output logic                 capture_en
);
	import pbl_pkg::*;

	logic tmr_out;

	// Recomputed combinationally from current register bits
	always_comb begin
		// Only the A side lets PWM select the timer output
		tmr_out = sel.tmr_oe && (sel.cmd || (IS_A && sel.pwm) || (sel.io[2:1] == 2'b01)
			|| (sel.io == 3'b001)); // see RL1 see RL4
		if (tmr_out) begin
			fn = PBL_FN_TIMER;
		end else if (!sel.dir) begin
			fn = PBL_FN_GP_IN; // see RL2 see RL5 see RL7
		end else if (sel.pat_en) begin
			fn = PBL_FN_PATTERN; // see RL3 see RL6
		end else begin
			fn = PBL_FN_GP_OUT;
		end
		capture_en = !tmr_out && !sel.cmd && !sel.pwm && sel.io[2]; // see RL2 see RL5
	end
endmodule

// *** hdl/pbl_port_b_low.sv ***
`include "pbl_defs.svh"

// Functional notes
// RL1: Pin one outputs channel-three B compare
// RL2: Pin one input, feeds B capture
// RL3: Pin one drives data or pattern bit
// RL4: Pin zero outputs channel-three A compare
// RL5: Pin zero input, feeds A capture
// RL6: Pin zero drives data or pattern bit
// RL7: Output enable low keeps port control
// RL8: Read returns data or pin level
// RL9: Pattern enable blocks processor data writes
// RL10: Selection follows registers without delay
module pbl_port_b_low (
	// Clock and reset
	input  logic                mclk,
	input  logic                resetn,
	input  logic                clk_en,
	// Register port
	input  pbl_pkg::pbl_bus_t   bus,
	output logic [7:0]          rdata,
	// Timer channel 3 side
	input  logic [1:0]          tmr_cmp_out,
	output logic [1:0]          tmr_cap_in,
	// Pins
	input  logic [1:0]          pin_in,
	output logic [1:0]          pin_out,
	output logic [1:0]          pin_oe
);
	import pbl_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  port_direction_reg_ff;
	logic [7:0]  port_data_reg_ff;
	logic [7:0]  pattern_enable_reg_ff;
	logic [7:0]  pattern_next_data_reg_ff;
	logic [7:0]  timer_mode_reg_ff;
	logic [7:0]  timer_function_ctrl_reg_ff;
	logic [7:0]  timer_output_enable_reg_ff;
	logic [7:0]  chan3_io_ctrl_reg_ff;
	logic [7:0]  nxt_rdata;
	logic        wr_hit_data;
	logic        xfer;

	assign wr_hit_data = bus.wr && (bus.addr == `PBL_OFF_DATA);
	assign xfer        = bus.wr && (bus.addr == `PBL_OFF_XFER);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			port_direction_reg_ff      <= `PBL_RST_REG;
			pattern_enable_reg_ff      <= `PBL_RST_REG;
			pattern_next_data_reg_ff   <= `PBL_RST_REG;
			timer_mode_reg_ff          <= `PBL_RST_REG;
			timer_function_ctrl_reg_ff <= `PBL_RST_REG;
			timer_output_enable_reg_ff <= `PBL_RST_REG;
			chan3_io_ctrl_reg_ff       <= `PBL_RST_REG;
		end else if (clk_en && bus.wr) begin
			case (bus.addr)
				`PBL_OFF_DIR:     port_direction_reg_ff      <= bus.wdata;
				`PBL_OFF_PAT_EN:  pattern_enable_reg_ff      <= bus.wdata;
				`PBL_OFF_PAT_NXT: pattern_next_data_reg_ff   <= bus.wdata;
				`PBL_OFF_TMODE:   timer_mode_reg_ff          <= bus.wdata;
				`PBL_OFF_TFUNC:   timer_function_ctrl_reg_ff <= bus.wdata;
				`PBL_OFF_TOE:     timer_output_enable_reg_ff <= bus.wdata;
				`PBL_OFF_TIO:     chan3_io_ctrl_reg_ff       <= bus.wdata;
				default: begin
				end
			endcase
		end
	end

	// Data bits: pattern-enabled bits only change by transfer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			port_data_reg_ff <= `PBL_RST_REG;
		end else if (clk_en) begin
			for (int i = 0; i < 8; i++) begin
				if (pattern_enable_reg_ff[i]) begin
					if (xfer) begin
						port_data_reg_ff[i] <= pattern_next_data_reg_ff[i]; // see RL9
					end
				end else if (wr_hit_data) begin
					port_data_reg_ff[i] <= bus.wdata[i]; // see RL9
				end
			end
		end
	end

	// ----------------------------------------
	// Pin selection
	// ----------------------------------------
	pbl_sel_in_t sel [2];
	pbl_fn_t     fn [2];
	logic [1:0]  cap_en;
	logic [1:0]  nxt_pin_out;
	logic [1:0]  nxt_pin_oe;
	logic [1:0]  nxt_cap_in;
	logic        cmd_bit;
	logic        pwm_bit;

	assign cmd_bit = timer_function_ctrl_reg_ff[`PBL_BIT_CMD];
	assign pwm_bit = timer_mode_reg_ff[`PBL_BIT_CHAN3_PWM_SELECT];

	assign sel[1] = '{dir: port_direction_reg_ff[`PBL_BIT_PIN1],
		pat_en: pattern_enable_reg_ff[`PBL_PAT_BIT9],
		tmr_oe: timer_output_enable_reg_ff[`PBL_BIT_EB3],
		cmd: cmd_bit, pwm: pwm_bit, io: chan3_io_ctrl_reg_ff[6:4]};
	assign sel[0] = '{dir: port_direction_reg_ff[`PBL_BIT_PIN0],
		pat_en: pattern_enable_reg_ff[`PBL_PAT_BIT8],
		tmr_oe: timer_output_enable_reg_ff[`PBL_BIT_EA3],
		cmd: cmd_bit, pwm: pwm_bit, io: chan3_io_ctrl_reg_ff[2:0]};

	generate
		for (genvar p = 0; p < 2; p++) begin : g_pin
			pbl_pin_sel #(
				.IS_A (p == 0)
			) u_sel (
				.sel        (sel[p]),
				.fn         (fn[p]),
				.capture_en (cap_en[p])
			);
			always_comb begin
				case (fn[p])
					PBL_FN_TIMER: begin
						nxt_pin_out[p] = tmr_cmp_out[p]; // see RL1 see RL4
						nxt_pin_oe[p]  = 1'b1;
					end
					PBL_FN_PATTERN: begin
						nxt_pin_out[p] = port_data_reg_ff[p]; // see RL3 see RL6
						nxt_pin_oe[p]  = 1'b1;
					end
					PBL_FN_GP_OUT: begin
						nxt_pin_out[p] = port_data_reg_ff[p];
						nxt_pin_oe[p]  = 1'b1;
					end
					default: begin
						nxt_pin_out[p] = 1'b0;
						nxt_pin_oe[p]  = 1'b0;
					end
				endcase
				nxt_cap_in[p] = cap_en[p] & pin_in[p];
			end
		end
	endgenerate

	// Registered pin drive, one cycle after the register write
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin_out    <= 2'h0;
			pin_oe     <= 2'h0;
			tmr_cap_in <= 2'h0;
		end else if (clk_en) begin
			pin_out    <= nxt_pin_out; // see RL10 see RL7
			pin_oe     <= nxt_pin_oe;
			tmr_cap_in <= nxt_cap_in;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		case (bus.addr)
			`PBL_OFF_DIR:     nxt_rdata = port_direction_reg_ff;
			`PBL_OFF_DATA:    nxt_rdata = {port_data_reg_ff[7:2],
				(port_direction_reg_ff[1:0] & port_data_reg_ff[1:0])
				| (~port_direction_reg_ff[1:0] & pin_in)}; // see RL8
			`PBL_OFF_PAT_EN:  nxt_rdata = pattern_enable_reg_ff;
			`PBL_OFF_PAT_NXT: nxt_rdata = pattern_next_data_reg_ff;
			`PBL_OFF_TMODE:   nxt_rdata = timer_mode_reg_ff;
			`PBL_OFF_TFUNC:   nxt_rdata = timer_function_ctrl_reg_ff;
			`PBL_OFF_TOE:     nxt_rdata = timer_output_enable_reg_ff;
			`PBL_OFF_TIO:     nxt_rdata = chan3_io_ctrl_reg_ff;
			default:          nxt_rdata = `PBL_RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (clk_en && bus.rd) begin
			rdata <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_b_timer_out: assert property (@(posedge mclk) disable iff (!resetn) // see RL1
		clk_en && timer_output_enable_reg_ff[`PBL_BIT_EB3] && cmd_bit
		|=> pin_oe[1] && pin_out[1] == $past(tmr_cmp_out[1]))
		else $error("pin one not timer output");
	chk_a_pwm_out: assert property (@(posedge mclk) disable iff (!resetn) // see RL4
		clk_en && timer_output_enable_reg_ff[`PBL_BIT_EA3] && pwm_bit
		|=> pin_oe[0] && pin_out[0] == $past(tmr_cmp_out[0]))
		else $error("pin zero not timer output");
	chk_b_input: assert property (@(posedge mclk) disable iff (!resetn) // see RL2
		clk_en && !timer_output_enable_reg_ff[`PBL_BIT_EB3]
		&& !port_direction_reg_ff[1] |=> !pin_oe[1])
		else $error("pin one should be input");
	chk_a_input: assert property (@(posedge mclk) disable iff (!resetn) // see RL5
		clk_en && !timer_output_enable_reg_ff[`PBL_BIT_EA3]
		&& !port_direction_reg_ff[0] |=> !pin_oe[0])
		else $error("pin zero should be input");
	chk_b_pattern: assert property (@(posedge mclk) disable iff (!resetn) // see RL3
		clk_en && !timer_output_enable_reg_ff[`PBL_BIT_EB3] && port_direction_reg_ff[1]
		|=> pin_oe[1] && pin_out[1] == $past(port_data_reg_ff[1]))
		else $error("pin one data drive wrong");
	chk_a_pattern: assert property (@(posedge mclk) disable iff (!resetn) // see RL6
		clk_en && !timer_output_enable_reg_ff[`PBL_BIT_EA3] && port_direction_reg_ff[0]
		|=> pin_oe[0] && pin_out[0] == $past(port_data_reg_ff[0]))
		else $error("pin zero data drive wrong");
	chk_oe_port: assert property (@(posedge mclk) disable iff (!resetn) // see RL7
		clk_en && timer_output_enable_reg_ff[4:3] == 2'b00
		|=> pin_oe == $past(port_direction_reg_ff[1:0]))
		else $error("port control lost");
	chk_read_mux: assert property (@(posedge mclk) disable iff (!resetn) // see RL8
		clk_en && bus.rd && bus.addr == `PBL_OFF_DATA && port_direction_reg_ff[0]
		|=> rdata[0] == $past(port_data_reg_ff[0]))
		else $error("read of output bit wrong");
	chk_write_block: assert property (@(posedge mclk) disable iff (!resetn) // see RL9
		clk_en && wr_hit_data && pattern_enable_reg_ff[0] && !xfer
		|=> $stable(port_data_reg_ff[0]))
		else $error("pattern bit overwritten");
	chk_b_capture: assert property (@(posedge mclk) disable iff (!resetn) // see RL2
		clk_en && cap_en[1] |=> tmr_cap_in[1] == $past(pin_in[1]))
		else $error("capture path wrong");

	cov_b_timer: cover property (@(posedge mclk) pin_oe[1] && fn[1] == PBL_FN_TIMER);
	cov_a_pattern: cover property (@(posedge mclk) fn[0] == PBL_FN_PATTERN);
	cov_capture: cover property (@(posedge mclk) tmr_cap_in[0]);
endmodule

// *** tb/pbl_board.sv ***
module pbl_board (
	// Block pin side
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	// Level held by the board on undriven pins
	input  wire logic [1:0] brd_level,
	output logic      [1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & brd_level);
endmodule

// *** tb/pbl_port_b_low_tb.sv ***
`include "pbl_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module pbl_port_b_low_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pbl_pkg::*;

	typedef struct packed {
		logic [7:0] dir, dat, pen, tmd, tfc, toe, tio;
		logic [1:0] cmp, brd, oe, out, cap;
	} pbl_row_t;

	logic       mclk        = 1'b0;
	logic       resetn      = 1'b0;
	logic       clk_en      = 1'b1;
	pbl_bus_t   bus         = '0;
	logic [1:0] tmr_cmp_out = 2'h0;
	logic [1:0] brd         = 2'h0;
	logic [7:0] rdata;
	logic [1:0] tmr_cap_in, pin_in, pin_out, pin_oe, pin;
	logic [7:0] got;
	pbl_row_t   r;
	int         err_count   = 0;
	int         checks_done = 0;
	int         cyc         = 0;

	// Register values, timer compare, board level, expected oe/out/capture
	pbl_row_t rows [11] = '{
		'{8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 2'h0, 2'h3, 2'h2, 2'h0},
		'{8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h18, 8'h00, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h11, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0},
		'{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h22, 2'h1, 2'h0, 2'h3, 2'h1, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h18, 8'h00, 2'h3, 2'h0, 2'h3, 2'h3, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h18, 8'h00, 2'h3, 2'h2, 2'h1, 2'h1, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h18, 8'h44, 2'h1, 2'h2, 2'h1, 2'h1, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h08, 8'h20, 8'h00, 8'h11, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0},
		'{8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01, 2'h1, 2'h0, 2'h3, 2'h3, 2'h0},
		'{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h30, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h44, 2'h0, 2'h3, 2'h0, 2'h0, 2'h3}
	};

	pbl_port_b_low u_dut (
		.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .bus(bus), .rdata(rdata),
		.tmr_cmp_out(tmr_cmp_out), .tmr_cap_in(tmr_cap_in),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
	);

	pbl_board u_board (
		.pin_out(pin_out), .pin_oe(pin_oe), .brd_level(brd), .pin_in(pin_in)
	);

	always #12.5 mclk = ~mclk;

	// ----
	// Bus tasks and verdict
	// ----
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1 d = rdata;
	endtask

	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			give_verdict();
		end
	end

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rd(`PBL_OFF_DATA, got);
		`CHK(got, `PBL_RST_REG);
		`CHK(pin_oe, 2'h0);
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge mclk);
			tmr_cmp_out <= r.cmp;
			brd <= r.brd;
			wr(`PBL_OFF_PAT_EN, 8'h00);
			wr(`PBL_OFF_DATA, r.dat);
			wr(`PBL_OFF_DIR, r.dir);
			wr(`PBL_OFF_PAT_EN, r.pen);
			wr(`PBL_OFF_TMODE, r.tmd);
			wr(`PBL_OFF_TFUNC, r.tfc);
			wr(`PBL_OFF_TOE, r.toe);
			wr(`PBL_OFF_TIO, r.tio);
			repeat (2) @(posedge mclk);
			#1;
			`CHK(pin_oe, r.oe);
			`CHK(pin_out & r.oe, r.out);
			`CHK(tmr_cap_in, r.cap);
			pin = (r.oe & r.out) | (~r.oe & r.brd);
			rd(`PBL_OFF_DATA, got);
			`CHK(got[1:0], (r.dir[1:0] & r.dat[1:0]) | (~r.dir[1:0] & pin));
		end
		// Pattern enable blocks direct data writes; transfer still loads
		wr(`PBL_OFF_TOE, 8'h00);
		wr(`PBL_OFF_DIR, 8'h03);
		wr(`PBL_OFF_PAT_EN, 8'h00);
		wr(`PBL_OFF_DATA, 8'h00);
		wr(`PBL_OFF_PAT_EN, 8'h02);
		wr(`PBL_OFF_DATA, 8'h03);
		rd(`PBL_OFF_DATA, got);
		`CHK(got[1:0], 2'h1);
		wr(`PBL_OFF_PAT_NXT, 8'h02);
		wr(`PBL_OFF_XFER, 8'h00);
		rd(`PBL_OFF_DATA, got);
		`CHK(got[1:0], 2'h3);
		rd(4'hf, got);
		`CHK(got, `PBL_RD_UNMAPPED);
		// Write with clock enable low is not taken
		wr(`PBL_OFF_DIR, 8'h03);
		clk_en <= 1'b0;
		wr(`PBL_OFF_DIR, 8'h00);
		clk_en <= 1'b1;
		rd(`PBL_OFF_DIR, got);
		`CHK(got[1:0], 2'h3);
		// Reset in mid-run
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd(`PBL_OFF_DIR, got);
		`CHK(got, `PBL_RST_REG);
		`CHK(pin_oe, 2'h0);
		give_verdict();
	end
endmodule
